//--- hdl/uesm_core.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "uesm_defs.svh"

module uesm_core #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire uesm_pkg::uesm_bus_t busReq,
  input wire uesm_pkg::uesm_evt_t evt,
  input wire logic funcRst,
  input wire logic ringPin,
  output logic [7:0] rdData,
  output logic irqReq,
  output logic ep0ForceNak,
  output logic wakeReq
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (SYNC_STAGES < 2) begin : gChk
    $error("SYNC_STAGES must be at least 2");
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  logic [7:0] rdData_reg;
  logic irq_reg;
  logic nak_reg;
  logic wake_reg;
  logic [SYNC_STAGES-1:0] ringSync_reg;
  logic ringPrev_reg;
  logic ringRise;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic [7:0] funcClr;
  logic wrFlags;
  logic wrEnable;
  logic rdFlags;
  logic rdEnable;

  // ****************************************
  // register decode
  // ****************************************
  assign wrFlags = busReq.wrStb && (busReq.addr == `UESM_FLAGS_ADDR);
  assign wrEnable = busReq.wrStb && (busReq.addr == `UESM_ENABLE_ADDR);
  assign rdFlags = busReq.rdStb && (busReq.addr == `UESM_FLAGS_ADDR);
  assign rdEnable = busReq.rdStb && (busReq.addr == `UESM_ENABLE_ADDR);

  // ****************************************
  // ring indicator pin
  // ****************************************
  // pin is asynchronous, so it crosses a plain shift chain first
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ringSync_reg <= '0;
    end else if (clkEn) begin
      ringSync_reg <= {ringSync_reg[SYNC_STAGES-2:0], ringPin};
    end
  end

  // edge detector looks only at the last stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ringPrev_reg <= 1'b0;
    end else if (clkEn) begin
      ringPrev_reg <= ringSync_reg[SYNC_STAGES-1];
    end
  end

  assign ringRise = ringSync_reg[SYNC_STAGES-1] && !ringPrev_reg;

  // ****************************************
  // event set vector
  // ****************************************
  // overwrite detection
  assign setVec[`UESM_BIT_OVERWRITE] = evt.setupRcvd && evt.setupBufBusy;
  assign setVec[`UESM_BIT_WAKEUP] = evt.remoteWake;
  assign setVec[`UESM_BIT_SETUP] = evt.setupRcvd;
  assign setVec[`UESM_BIT_RING] = ringRise;
  assign setVec[4] = 1'b0; // reserved, never set
  assign setVec[`UESM_BIT_RESUME] = evt.resumeDet;
  assign setVec[`UESM_BIT_SUSPEND] = evt.globalSusp || evt.selectSusp;
  assign setVec[`UESM_BIT_BUSRESET] = evt.busResetDet;

  // ****************************************
  // flag clear sources
  // ****************************************
  // write one clears
  assign clrVec = wrFlags ? (busReq.wrData & `UESM_IMPL_MASK) : 8'h00;
  assign funcClr = funcRst ? ~`UESM_FUNC_KEEP : 8'h00;

  // one slice per flag; set beats any clear landing in the same cycle
  for (genvar i = 0; i < 8; i++) begin : gFlag
    assign flags_next[i] = (flags_reg[i] && !clrVec[i] && !funcClr[i])
      || setVec[i];
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags_reg <= `UESM_FLAGS_RESET;
    end else if (clkEn) begin
      flags_reg <= flags_next;
    end
  end

  // ****************************************
  // interrupt enable register
  // ****************************************
  // a write in the same cycle as a function reset wins
  always_comb begin
    enable_next = enable_reg;
    if (wrEnable) begin
      enable_next = busReq.wrData & `UESM_IMPL_MASK;
    end else if (funcRst) begin
      enable_next = enable_reg & `UESM_FUNC_KEEP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      enable_reg <= `UESM_ENABLE_RESET;
    end else if (clkEn) begin
      enable_reg <= enable_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // built from next values so the request tracks the flags exactly
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      irq_reg <= |(flags_next & enable_next);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      nak_reg <= 1'b0;
    end else if (clkEn) begin
      nak_reg <= flags_next[`UESM_BIT_SETUP];
    end
  end

  // one-cycle wake pulse; the suspend logic elsewhere latches it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wake_reg <= 1'b0;
    end else if (clkEn) begin
      wake_reg <= ringRise;
    end
  end

  // read data only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdData_reg <= `UESM_READ_IDLE;
    end else if (clkEn) begin
      if (rdFlags) begin
        rdData_reg <= flags_reg;
      end else if (rdEnable) begin
        rdData_reg <= enable_reg;
      end else begin
        rdData_reg <= `UESM_READ_IDLE;
      end
    end
  end

  assign rdData = rdData_reg;
  assign irqReq = irq_reg;
  assign ep0ForceNak = nak_reg;
  assign wakeReq = wake_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // a one clears unless the same bit is set that cycle
  clear_by_one_a: assert property (
    clkEn && wrFlags |=>
      ((flags_reg & $past(busReq.wrData) & `UESM_IMPL_MASK) ==
       ($past(setVec) & $past(busReq.wrData) & `UESM_IMPL_MASK)))
    else $error("flag written with one did not clear");

  zero_keeps_a: assert property (
    clkEn && wrFlags && !funcRst |=>
      ((flags_reg & ~$past(busReq.wrData)) ==
       (($past(flags_reg) | $past(setVec)) & ~$past(busReq.wrData))))
    else $error("flag written with zero changed");

  no_soft_set_a: assert property (
    clkEn |=> ((flags_reg & ~$past(flags_reg) & ~$past(setVec)) == 8'h00))
    else $error("flag rose without a hardware event");

  irq_gate_a: assert property (
    (irqReq == (|(flags_reg & enable_reg))))
    else $error("interrupt request disagrees with flags and enables");

  overwrite_set_a: assert property (
    clkEn && evt.setupRcvd && evt.setupBufBusy |=>
      flags_reg[`UESM_BIT_OVERWRITE] && flags_reg[`UESM_BIT_SETUP])
    else $error("setup overwrite not flagged");

  suspend_set_a: assert property (
    clkEn && (evt.globalSusp || evt.selectSusp) |=>
      flags_reg[`UESM_BIT_SUSPEND])
    else $error("suspend not flagged");

  // a write landing with a function reset wins, so no funcRst term here
  enable_write_a: assert property (
    clkEn && wrEnable |=>
      (enable_reg == ($past(busReq.wrData) & `UESM_IMPL_MASK)))
    else $error("enable register did not take the write");

  func_enable_a: assert property (
    clkEn && funcRst && !wrEnable |=>
      (enable_reg == ($past(enable_reg) & `UESM_FUNC_KEEP)))
    else $error("function reset mishandled the enables");

  func_flag_a: assert property (
    clkEn && funcRst && !wrFlags |=>
      flags_reg[`UESM_BIT_BUSRESET] ==
      ($past(flags_reg[7]) || $past(setVec[7])))
    else $error("function reset disturbed the bus reset flag");

  nak_follow_a: assert property (
    ep0ForceNak == flags_reg[`UESM_BIT_SETUP])
    else $error("endpoint zero nak does not follow setup flag");

  ring_wake_a: assert property (
    clkEn && ringRise |=> flags_reg[`UESM_BIT_RING] && wakeReq)
    else $error("ring edge did not flag and wake");

  reset_resume_a: assert property (
    clkEn && evt.busResetDet && evt.resumeDet |=>
      flags_reg[`UESM_BIT_BUSRESET] && flags_reg[`UESM_BIT_RESUME])
    else $error("port reset or resume not flagged");

  read_flags_a: assert property (
    clkEn && rdFlags |=> rdData == $past(flags_reg))
    else $error("flag read returned wrong data");

  // read port answers once, then falls back to idle
  read_enable_a: assert property (
    clkEn && rdEnable |=> rdData == $past(enable_reg))
    else $error("enable read returned wrong data");

  read_idle_a: assert property (
    clkEn && !rdFlags && !rdEnable |=> rdData == `UESM_READ_IDLE)
    else $error("read data not idle outside an answer");

  // reserved bit and clock enable freeze
  reserved_zero_a: assert property (
    !flags_reg[4] && !enable_reg[4])
    else $error("reserved bit 4 became set");

  freeze_state_a: assert property (
    !clkEn |=> $stable(flags_reg) && $stable(enable_reg) && $stable(rdData))
    else $error("state moved while the clock enable was low");

  // single-event set paths
  wakeup_set_a: assert property (
    clkEn && evt.remoteWake |=> flags_reg[`UESM_BIT_WAKEUP])
    else $error("remote wakeup not flagged");

  setup_set_a: assert property (
    clkEn && evt.setupRcvd |=> flags_reg[`UESM_BIT_SETUP] && ep0ForceNak)
    else $error("setup receipt not flagged");

  resume_set_a: assert property (
    clkEn && evt.resumeDet |=> flags_reg[`UESM_BIT_RESUME])
    else $error("function resume not flagged");

  busreset_set_a: assert property (
    clkEn && evt.busResetDet |=> flags_reg[`UESM_BIT_BUSRESET])
    else $error("host port reset not flagged");

  // wake pulse is one cycle and only follows a ring edge
  wake_pulse_a: assert property (
    clkEn && wakeReq |=> !wakeReq)
    else $error("wake request held longer than one cycle");

  no_false_wake_a: assert property (
    clkEn && !ringRise |=> !wakeReq)
    else $error("wake request without a ring edge");

  // request gating, function reset clearing and clear-only flag writes
  irq_quiet_a: assert property (
    enable_reg == 8'h00 |-> !irqReq)
    else $error("interrupt request with every enable clear");

  func_clear_a: assert property (
    clkEn && funcRst && !wrEnable && (setVec[6:0] == 7'h00) |=>
      (flags_reg[6:0] == 7'h00) && (enable_reg[6:0] == 7'h00))
    else $error("function reset left low flags or enables");

  write_only_clears_a: assert property (
    clkEn && wrFlags && (setVec == 8'h00) |=>
      ((flags_reg & ~$past(flags_reg)) == 8'h00))
    else $error("flag write raised a flag");

  // ****************************************
  // covers
  // ****************************************
  irq_then_clear_c: cover property (
    irqReq && clkEn && wrFlags ##1 !irqReq);

  ring_edge_c: cover property (clkEn && ringRise ##1 wakeReq);

  overwrite_irq_c: cover property (
    clkEn && evt.setupRcvd && evt.setupBufBusy ##1 irqReq);

  func_keep_c: cover property (
    flags_reg[`UESM_BIT_BUSRESET] && clkEn && funcRst
    ##1 flags_reg[`UESM_BIT_BUSRESET]);

  set_beats_clear_c: cover property (
    clkEn && wrFlags && |(setVec & busReq.wrData));

endmodule

`default_nettype wire

//--- inc/uesm_defs.svh
`ifndef UESM_DEFS_SVH
`define UESM_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define UESM_ENABLE_ADDR 16'hFFFD
`define UESM_FLAGS_ADDR 16'hFFFE

// ****************************************
// field positions
// ****************************************
`define UESM_BIT_OVERWRITE 0
`define UESM_BIT_WAKEUP 1
`define UESM_BIT_SETUP 2
`define UESM_BIT_RING 3
`define UESM_BIT_RESUME 5
`define UESM_BIT_SUSPEND 6
`define UESM_BIT_BUSRESET 7

// ****************************************
// reset values and masks
// ****************************************
`define UESM_ENABLE_RESET 8'h00
`define UESM_FLAGS_RESET 8'h00
`define UESM_IMPL_MASK 8'hEF
`define UESM_FUNC_KEEP 8'h80
`define UESM_READ_IDLE 8'h00

`endif

//--- inc/uesm_pkg.sv
package uesm_pkg;

  // one register access from the local microcontroller
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } uesm_bus_t;

  // event sources from the usb engine, all on ref_clk
  typedef struct packed {
    logic setupRcvd;
    logic setupBufBusy;
    logic remoteWake;
    logic resumeDet;
    logic globalSusp;
    logic selectSusp;
    logic busResetDet;
  } uesm_evt_t;

endpackage

//--- verif/tb_usb_event_status_mask.sv
`timescale 1ns/10ps
`default_nettype none
`include "uesm_defs.svh"

module tb_usb_event_status_mask;
  logic ref_clk, nrst, clkEn, funcRst, ringPin;
  uesm_pkg::uesm_bus_t busReq;
  uesm_pkg::uesm_evt_t evt;
  logic [7:0] rdData;
  logic irqReq, ep0ForceNak, wakeReq;
  int failures, samples_checked, cycles;
  int flags, en, rdExp;
  bit s1, s2, s3, wakeExp, armed;
  // event pattern that sets each flag bit; bits 3 and 4 have none
  logic [6:0] evtTab [8] = '{7'h60, 7'h10, 7'h40, 7'h00, 7'h00, 7'h08,
                             7'h04, 7'h01};

  uesm_core #(.SYNC_STAGES(2)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .clkEn(clkEn), .busReq(busReq), .evt(evt), .funcRst(funcRst),
    .ringPin(ringPin), .rdData(rdData), .irqReq(irqReq),
    .ep0ForceNak(ep0ForceNak), .wakeReq(wakeReq));

  // ****************************************
  // clock and cycle limit
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // a hung run counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ****************************************
  // reference model
  // ****************************************
  // order matters: function reset, then write-one clear, then hardware set
  always @(posedge ref_clk) begin
    int set;
    armed = 1'b1;
    if (nrst !== 1'b1) begin
      flags = 0;
      en = 0;
      rdExp = 0;
      {s1, s2, s3, wakeExp} = 4'h0;
    end else if (clkEn === 1'b1) begin
      set = {evt.busResetDet, evt.globalSusp | evt.selectSusp, evt.resumeDet,
             1'b0, s2 & ~s3, evt.setupRcvd, evt.remoteWake,
             evt.setupRcvd & evt.setupBufBusy};
      wakeExp = s2 & ~s3;
      {s3, s2, s1} = {s2, s1, ringPin};
      rdExp = 0;
      if (busReq.rdStb && busReq.addr == `UESM_FLAGS_ADDR)
        rdExp = flags;
      if (busReq.rdStb && busReq.addr == `UESM_ENABLE_ADDR)
        rdExp = en;
      if (funcRst) begin
        flags &= `UESM_FUNC_KEEP;
        en &= `UESM_FUNC_KEEP;
      end
      if (busReq.wrStb && busReq.addr == `UESM_ENABLE_ADDR)
        en = busReq.wrData & `UESM_IMPL_MASK;
      if (busReq.wrStb && busReq.addr == `UESM_FLAGS_ADDR)
        flags &= ~busReq.wrData;
      flags |= set;
    end
  end

  // ****************************************
  // comparison and report
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // outputs are settled at the falling edge
  always @(negedge ref_clk) if (armed) begin
    chk(rdData, 8'(rdExp));
    chk({7'h00, irqReq}, {7'h00, |(flags & en)});
    chk({7'h00, ep0ForceNak}, {7'h00, flags[2]});
    chk({7'h00, wakeReq}, {7'h00, wakeExp});
  end

  // ****************************************
  // bus driver
  // ****************************************
  function automatic uesm_pkg::uesm_bus_t mk(input logic [15:0] a,
      input logic [7:0] d, input logic w, input logic r);
    mk = {a, d, w, r};
  endfunction

  task automatic tick(input uesm_pkg::uesm_bus_t b, input logic [6:0] e);
    @(posedge ref_clk);
    busReq <= b;
    evt <= e;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick(mk(a, d, 1'b1, 1'b0), 7'h00);
  endtask

  task automatic rd(input logic [15:0] a);
    tick(mk(a, 8'h00, 1'b0, 1'b1), 7'h00);
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    int r;
    logic [15:0] a;
    nrst = 1'b0;
    clkEn = 1'b1;
    funcRst = 1'b0;
    ringPin = 1'b0;
    busReq = '0;
    evt = '0;
    void'($urandom(23));
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    // reset values, then an unmapped address
    rd(`UESM_ENABLE_ADDR);
    rd(`UESM_FLAGS_ADDR);
    rd(16'h1234);
    // walk each flag with only its own enable set
    for (int i = 0; i < 8; i++) begin
      wr(`UESM_ENABLE_ADDR, 8'h01 << i);
      tick('0, evtTab[i]);
      ringPin <= (i == 3);
      tick('0, 7'h00);
      ringPin <= 1'b0;
      repeat (4) tick('0, 7'h00);
      rd(`UESM_FLAGS_ADDR);
      wr(`UESM_FLAGS_ADDR, 8'h00);
      rd(`UESM_FLAGS_ADDR);
      wr(`UESM_FLAGS_ADDR, 8'h01 << i);
      rd(`UESM_ENABLE_ADDR);
    end
    // function reset spares only the bus-reset flag and enable
    wr(`UESM_ENABLE_ADDR, 8'hFF);
    tick('0, 7'h7F);
    tick('0, 7'h00);
    funcRst <= 1'b1;
    tick('0, 7'h00);
    funcRst <= 1'b0;
    rd(`UESM_ENABLE_ADDR);
    rd(`UESM_FLAGS_ADDR);
    // let the flag read answer before reset wipes the read port
    tick('0, 7'h00);
    // a second reset in mid-run clears what function reset kept
    nrst <= 1'b0;
    repeat (2) tick('0, 7'h00);
    nrst <= 1'b1;
    rd(`UESM_ENABLE_ADDR);
    rd(`UESM_FLAGS_ADDR);
    // random traffic: sparse events, stalls and function resets
    for (int k = 0; k < 3000; k++) begin
      r = $urandom % 4;
      a = ($urandom % 3 == 0) ? `UESM_FLAGS_ADDR :
          ($urandom % 2 == 1) ? `UESM_ENABLE_ADDR : 16'($urandom);
      tick(mk(a, 8'($urandom), r == 0, r == 1),
           7'($urandom & $urandom & $urandom));
      clkEn <= ($urandom % 8) != 0;
      funcRst <= ($urandom % 40) == 0;
      if ($urandom % 10 == 0)
        ringPin <= ~ringPin;
    end
    repeat (4) tick('0, 7'h00);
    conclude();
  end
endmodule

`default_nettype wire
